// File: core/cmpmx_regs.sv
// Comparator mode select and input select registers with edge interrupt gating
// Functional notes
// R1: Rising-edge enable gates rising interrupts
// R2: Falling-edge enable gates falling interrupts
// R3: Bits 1:0 set response speed/power mode
// R4: Mode bits 7:6, 3:2 read zero
// R5: Select bits 7 and 3 read zero
// R6: Bits 6:4 choose negative input pin
// R7: Bits 2:0 choose positive input pin
// R8: Small packages: rail pin, internal positive
// R9: Software makes chosen pins analog, skipped
// R10: Software drives internal positive to rail
// R11: Edges set sticky flags until cleared
// R12: Disabled comparator port output reads low
// R13: Interrupt when flag and enable both set
`timescale 1ns/10ps
module cmpmx_regs #(
    parameter int PKG_PINS = 64
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic cmp_raw_in,
    input wire logic cmp_enable_in,
    input wire logic rise_clr_in,
    input wire logic fall_clr_in,
    output logic cmp_state_out,
    output logic rise_edge_flag_out,
    output logic fall_edge_flag_out,
    output logic irq_out,
    output logic cmp_port_out,
    output logic [1:0] response_mode_out,
    output logic [4:0] neg_sel_out,
    output logic [3:0] pos_sel_out
);
    // ==========================================================
    // Parameter check
    generate
        if (PKG_PINS != cmpmx_pkg::CMPMX_PKG_64 && PKG_PINS != cmpmx_pkg::CMPMX_PKG_48 &&
            PKG_PINS != cmpmx_pkg::CMPMX_PKG_32 && PKG_PINS != cmpmx_pkg::CMPMX_PKG_24)
        begin : g_bad_pkg
            $error("PKG_PINS must be 64, 48, 32 or 24");
        end
    endgenerate

    localparam bit SMALL_PKG = (PKG_PINS == cmpmx_pkg::CMPMX_PKG_32) ||
                               (PKG_PINS == cmpmx_pkg::CMPMX_PKG_24);
    localparam bit FULL_PKG = (PKG_PINS == cmpmx_pkg::CMPMX_PKG_64);

    // ==========================================================
    // Input select decodes
    // Negative: bits 0..3 are the four port pins, bit 4 the rail-sense pin
    function automatic logic [4:0] neg_decode(input logic [2:0] code);
        logic [4:0] sel;
        sel = 5'h00;
        if (SMALL_PKG)
        begin
            if (code == cmpmx_pkg::CMPMX_SEL_CODE3)
                sel = 5'h10; // R8
        end
        else if (code == cmpmx_pkg::CMPMX_SEL_CODE0 || code == cmpmx_pkg::CMPMX_SEL_CODE1)
            sel = 5'h01 << code[1:0]; // R6
        else if (FULL_PKG && !code[2])
            sel = 5'h01 << code[1:0]; // R6
        return sel;
    endfunction

    // Positive: code 3 stays routed on small parts though it has no pin
    function automatic logic [3:0] pos_decode(input logic [2:0] code);
        logic [3:0] sel;
        sel = 4'h0;
        if (SMALL_PKG)
        begin
            if (code == cmpmx_pkg::CMPMX_SEL_CODE3)
                sel = 4'h8; // R8
        end
        else if (code == cmpmx_pkg::CMPMX_SEL_CODE0 || code == cmpmx_pkg::CMPMX_SEL_CODE1)
            sel = 4'h1 << code[1:0]; // R7
        else if (FULL_PKG && !code[2])
            sel = 4'h1 << code[1:0]; // R7
        return sel;
    endfunction

    // ==========================================================
    // Edge flag unit
    cmpmx_flag_if fl ();

    assign fl.cmp_raw = cmp_raw_in;
    assign fl.cmp_enable = cmp_enable_in;
    assign fl.rise_clr = rise_clr_in;
    assign fl.fall_clr = fall_clr_in;

    cmpmx_edge_flags u_flags (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .fl(fl)
    );

    // ==========================================================
    // Register state
    logic [7:0] mode_reg, mux_reg, rdata;
    logic port_q;
    logic [7:0] next_mode_reg, next_mux_reg, next_rdata;
    logic next_port_q;

    // Write, read and port output next values
    always_comb
    begin
        next_mode_reg = mode_reg;
        next_mux_reg = mux_reg;
        next_rdata = 8'h00;
        // Masked writes keep unused bits at zero for good
        if (sfr_wr_in && sfr_addr_in == cmpmx_pkg::CMPMX_ADDR_MODE)
            next_mode_reg = sfr_wdata_in & cmpmx_pkg::CMPMX_MODE_WMASK; // R4
        else if (sfr_wr_in && sfr_addr_in == cmpmx_pkg::CMPMX_ADDR_MUX)
            next_mux_reg = sfr_wdata_in & cmpmx_pkg::CMPMX_MUX_WMASK; // R5
        // Unmapped reads answer zero
        if (sfr_rd_in && sfr_addr_in == cmpmx_pkg::CMPMX_ADDR_MODE)
            next_rdata = mode_reg & cmpmx_pkg::CMPMX_MODE_WMASK; // R4
        else if (sfr_rd_in && sfr_addr_in == cmpmx_pkg::CMPMX_ADDR_MUX)
            next_rdata = mux_reg & cmpmx_pkg::CMPMX_MUX_WMASK; // R5
        // Powered-down comparator shows low at the port
        next_port_q = cmp_enable_in & fl.cmp_level; // R12
    end

    // Registers only
    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            mode_reg <= cmpmx_pkg::CMPMX_MODE_RESET;
            mux_reg <= cmpmx_pkg::CMPMX_MUX_RESET;
            rdata <= 8'h00;
            port_q <= 1'b0;
        end
        else
        begin
            mode_reg <= next_mode_reg;
            mux_reg <= next_mux_reg;
            rdata <= next_rdata;
            port_q <= next_port_q;
        end
    end

    // ==========================================================
    // Outputs
    logic rise_ie, fall_ie;
    logic [2:0] neg_code, pos_code;

    assign rise_ie = mode_reg[cmpmx_pkg::CMPMX_RISE_IE_BIT];
    assign fall_ie = mode_reg[cmpmx_pkg::CMPMX_FALL_IE_BIT];
    assign neg_code = mux_reg[cmpmx_pkg::CMPMX_NEG_LSB +: cmpmx_pkg::CMPMX_SEL_W];
    assign pos_code = mux_reg[cmpmx_pkg::CMPMX_POS_LSB +: cmpmx_pkg::CMPMX_SEL_W];
    assign sfr_rdata_out = rdata;
    assign cmp_state_out = fl.cmp_level;
    assign rise_edge_flag_out = fl.rise_flag;
    assign fall_edge_flag_out = fl.fall_flag;
    // Masks act on the request only; flags stay readable regardless
    assign irq_out = (fl.rise_flag & rise_ie) | (fl.fall_flag & fall_ie); // R1 R2 R13
    assign cmp_port_out = port_q;
    assign response_mode_out = mode_reg[cmpmx_pkg::CMPMX_RESP_LSB +: cmpmx_pkg::CMPMX_RESP_W]; // R3
    assign neg_sel_out = neg_decode(neg_code);
    assign pos_sel_out = pos_decode(pos_code);

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    // Interrupt request gating
    AST_RISE_GATED: assert property (fl.rise_flag && rise_ie |-> irq_out) // R1
        else $error("enabled rising flag gave no interrupt");
    AST_RISE_MASKED: assert property (!rise_ie && !(fl.fall_flag && fall_ie) |-> !irq_out) // R1
        else $error("interrupt with rising edge masked");
    AST_FALL_GATED: assert property (fl.fall_flag && fall_ie |-> irq_out) // R2
        else $error("enabled falling flag gave no interrupt");
    AST_FALL_MASKED: assert property (!fall_ie && !(fl.rise_flag && rise_ie) |-> !irq_out) // R2
        else $error("interrupt with falling edge masked");
    AST_IRQ_CAUSE: assert property (irq_out |-> (fl.rise_flag && rise_ie) || (fl.fall_flag && fall_ie)) // R13
        else $error("interrupt without enabled flag");

    // Register bus: writes land next cycle, reads answer for one cycle
    AST_RESP_WRITE: assert property (sfr_wr_in && sfr_addr_in == cmpmx_pkg::CMPMX_ADDR_MODE |=> // R3
        response_mode_out == $past(sfr_wdata_in[cmpmx_pkg::CMPMX_RESP_LSB +: cmpmx_pkg::CMPMX_RESP_W]))
        else $error("response mode not taken from write");
    AST_MUX_WRITE: assert property (sfr_wr_in && sfr_addr_in == cmpmx_pkg::CMPMX_ADDR_MUX |=> // R6 R7
        {1'b0, neg_code, 1'b0, pos_code} == ($past(sfr_wdata_in) & cmpmx_pkg::CMPMX_MUX_WMASK))
        else $error("input select codes not taken from write");
    AST_MODE_UNUSED: assert property (sfr_rd_in && sfr_addr_in == cmpmx_pkg::CMPMX_ADDR_MODE |=> // R4
        (sfr_rdata_out & ~cmpmx_pkg::CMPMX_MODE_WMASK) == 8'h00)
        else $error("unused mode bits read nonzero");
    AST_MUX_UNUSED: assert property (sfr_rd_in && sfr_addr_in == cmpmx_pkg::CMPMX_ADDR_MUX |=> // R5
        (sfr_rdata_out & ~cmpmx_pkg::CMPMX_MUX_WMASK) == 8'h00)
        else $error("unused select bits read nonzero");
    AST_RDATA_IDLE: assert property (!sfr_rd_in |=> sfr_rdata_out == 8'h00)
        else $error("read data not zero outside a read");

    // Input routing per package
    AST_NEG_NONE: assert property (neg_code[2] |-> neg_sel_out == 5'h00) // R6
        else $error("negative codes 4 to 7 routed a pin");
    AST_POS_NONE: assert property (pos_code[2] |-> pos_sel_out == 4'h0) // R7
        else $error("positive codes 4 to 7 routed a pin");
    AST_MID_NEG: assert property (!SMALL_PKG && !FULL_PKG && neg_code[1] |-> neg_sel_out == 5'h00) // R6
        else $error("mid package negative code 2 or 3 routed a pin");
    AST_MID_POS: assert property (!SMALL_PKG && !FULL_PKG && pos_code[1] |-> pos_sel_out == 4'h0) // R7
        else $error("mid package positive code 2 or 3 routed a pin");
    AST_WIDE_NO_RAIL: assert property (!SMALL_PKG |-> !neg_sel_out[4]) // R8
        else $error("rail pin routed on a large package");
    AST_SMALL_RAIL_NEG: assert property (SMALL_PKG && neg_code == cmpmx_pkg::CMPMX_SEL_CODE3 |-> // R8
        neg_sel_out == 5'h10)
        else $error("small package negative code 3 not routed to rail pin");
    AST_SMALL_RAIL_POS: assert property (SMALL_PKG && pos_code == cmpmx_pkg::CMPMX_SEL_CODE3 |-> // R8
        pos_sel_out == 4'h8)
        else $error("small package positive code 3 not routed internally");

    // Port output
    AST_PORT_LOW: assert property (!cmp_enable_in |=> !cmp_port_out) // R12
        else $error("port output high while disabled");
endmodule

// File: core/cmpmx_pkg.sv
// Constants and types shared by the comparator mode and mux register block
package cmpmx_pkg;
    // ==========================================================
    // Register addresses on the special function register bus
    localparam logic [7:0] CMPMX_ADDR_MODE = 8'h9d;
    localparam logic [7:0] CMPMX_ADDR_MUX = 8'h9f;
    // ==========================================================
    // Reset values and writable bit masks
    localparam logic [7:0] CMPMX_MODE_RESET = 8'h02;
    localparam logic [7:0] CMPMX_MUX_RESET = 8'h00;
    localparam logic [7:0] CMPMX_MODE_WMASK = 8'h33;
    localparam logic [7:0] CMPMX_MUX_WMASK = 8'h77;
    // ==========================================================
    // Field positions
    localparam int CMPMX_RISE_IE_BIT = 5;
    localparam int CMPMX_FALL_IE_BIT = 4;
    localparam int CMPMX_RESP_LSB = 0;
    localparam int CMPMX_RESP_W = 2;
    localparam int CMPMX_NEG_LSB = 4;
    localparam int CMPMX_POS_LSB = 0;
    localparam int CMPMX_SEL_W = 3;
    // ==========================================================
    // Input select codes and package sizes
    localparam logic [2:0] CMPMX_SEL_CODE0 = 3'h0;
    localparam logic [2:0] CMPMX_SEL_CODE1 = 3'h1;
    localparam logic [2:0] CMPMX_SEL_CODE2 = 3'h2;
    localparam logic [2:0] CMPMX_SEL_CODE3 = 3'h3;
    localparam int CMPMX_PKG_64 = 64;
    localparam int CMPMX_PKG_48 = 48;
    localparam int CMPMX_PKG_32 = 32;
    localparam int CMPMX_PKG_24 = 24;
    // ==========================================================
    // Response time versus power modes
    typedef enum logic [1:0] {
        CMPMX_RESP_FASTEST = 2'b00,
        CMPMX_RESP_MID1 = 2'b01,
        CMPMX_RESP_MID2 = 2'b10,
        CMPMX_RESP_SLOWEST = 2'b11
    } cmpmx_resp_t;
endpackage

// File: core/cmpmx_flag_if.sv
// Carrier between the register block and its edge flag unit
`timescale 1ns/10ps
interface cmpmx_flag_if;
    logic cmp_raw;
    logic cmp_enable;
    logic rise_clr;
    logic fall_clr;
    logic cmp_level;
    logic rise_flag;
    logic fall_flag;
    modport flags (input cmp_raw, input cmp_enable, input rise_clr, input fall_clr,
                   output cmp_level, output rise_flag, output fall_flag);
    modport user (output cmp_raw, output cmp_enable, output rise_clr, output fall_clr,
                  input cmp_level, input rise_flag, input fall_flag);
endinterface

// File: core/cmpmx_edge_flags.sv
// Comparator output synchroniser with sticky rising and falling edge flags
`timescale 1ns/10ps
module cmpmx_edge_flags (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    cmpmx_flag_if.flags fl
);
    // ==========================================================
    // Synchroniser and flag state
    logic sync1, sync2, sync3, level, rise_flag, fall_flag;
    logic next_level, next_rise_flag, next_fall_flag, rise_evt, fall_evt;

    // Level moves only when stages two and three agree
    always_comb
    begin
        next_level = (sync2 == sync3) ? sync3 : level;
        rise_evt = fl.cmp_enable & next_level & ~level;
        fall_evt = fl.cmp_enable & ~next_level & level;
        // Set beats clear so an edge in the clearing cycle survives
        next_rise_flag = rise_evt | (rise_flag & ~fl.rise_clr); // R11
        next_fall_flag = fall_evt | (fall_flag & ~fl.fall_clr); // R11
    end

    // Registers only
    always_ff @(posedge ref_clk_in)
    begin
        if (!nrst_in)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            level <= 1'b0;
            rise_flag <= 1'b0;
            fall_flag <= 1'b0;
        end
        else
        begin
            sync1 <= fl.cmp_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            level <= next_level;
            rise_flag <= next_rise_flag;
            fall_flag <= next_fall_flag;
        end
    end

    assign fl.cmp_level = level;
    assign fl.rise_flag = rise_flag;
    assign fl.fall_flag = fall_flag;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    AST_RISE_SETS: assert property (rise_evt |=> rise_flag) // R11
        else $error("rising edge did not set flag");
    AST_FALL_HOLDS: assert property (fall_flag && !fl.fall_clr |=> fall_flag) // R11
        else $error("falling flag dropped without clear");
endmodule

// File: tb/cmpmx_regs_tb_top.sv
// Self-checking bench for the comparator mode and input select registers
`timescale 1ns/10ps
module cmpmx_regs_tb_top;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic raw = 1'b0;
    logic en = 1'b0;
    logic rclr = 1'b0;
    logic fclr = 1'b0;
    logic [7:0] rdata;
    logic [7:0] ra;
    logic state, rflag, fflag, irq, port;
    logic [1:0] resp;
    logic [4:0] neg, neg_s, neg_m;
    logic [3:0] pos, pos_s, pos_m;
    int failures = 0;
    int checked = 0;
    int mode_m = 2;
    int mux_m = 0;
    int rf_m = 0;
    int ff_m = 0;
    int i;
    int unsigned seed = 27;
    // ==========================================================
    // Largest package fully exercised; mid and smallest ones only for their select decode
    cmpmx_regs #(.PKG_PINS(64)) u_dut (
        .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata), .cmp_raw_in(raw), .cmp_enable_in(en),
        .rise_clr_in(rclr), .fall_clr_in(fclr), .cmp_state_out(state), .rise_edge_flag_out(rflag),
        .fall_edge_flag_out(fflag), .irq_out(irq), .cmp_port_out(port), .response_mode_out(resp),
        .neg_sel_out(neg), .pos_sel_out(pos));
    cmpmx_regs #(.PKG_PINS(24)) u_dut_small (
        .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(), .cmp_raw_in(raw), .cmp_enable_in(en),
        .rise_clr_in(rclr), .fall_clr_in(fclr), .cmp_state_out(), .rise_edge_flag_out(),
        .fall_edge_flag_out(), .irq_out(), .cmp_port_out(), .response_mode_out(),
        .neg_sel_out(neg_s), .pos_sel_out(pos_s));
    cmpmx_regs #(.PKG_PINS(48)) u_dut_mid (
        .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(), .cmp_raw_in(raw), .cmp_enable_in(en),
        .rise_clr_in(rclr), .fall_clr_in(fclr), .cmp_state_out(), .rise_edge_flag_out(),
        .fall_edge_flag_out(), .irq_out(), .cmp_port_out(), .response_mode_out(),
        .neg_sel_out(neg_m), .pos_sel_out(pos_m));
    // ==========================================================
    // Clock, random source and reference decode
    initial
    begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Small packages keep only code 3: rail pin on the minus side, internal net on the plus side
    function automatic logic [7:0] dec(input int pins, input int code, input bit is_neg);
        if ((pins == 64 && code < 4) || (pins == 48 && code < 2))
            return 8'h01 << code;
        if (pins <= 32 && code == 3)
            return is_neg ? 8'h10 : 8'h08;
        return 8'h00;
    endfunction
    // ==========================================================
    // Comparison, bus and closing tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check_outs();
        chk({6'h00, resp}, 8'(mode_m & 3), "mode");
        chk({3'h0, neg}, dec(64, (mux_m >> 4) & 7, 1), "neg");
        chk({4'h0, pos}, dec(64, mux_m & 7, 0), "pos");
        chk({3'h0, neg_s}, dec(24, (mux_m >> 4) & 7, 1), "neg small");
        chk({4'h0, pos_s}, dec(24, mux_m & 7, 0), "pos small");
        chk({3'h0, neg_m}, dec(48, (mux_m >> 4) & 7, 1), "neg mid");
        chk({4'h0, pos_m}, dec(48, mux_m & 7, 0), "pos mid");
        chk({7'h00, irq}, 8'(((rf_m & (mode_m >> 5)) | (ff_m & (mode_m >> 4))) & 1), "irq");
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
        if (a == cmpmx_pkg::CMPMX_ADDR_MODE)
            mode_m = d & 8'h33;
        if (a == cmpmx_pkg::CMPMX_ADDR_MUX)
            mux_m = d & 8'h77;
        #1;
        check_outs();
    endtask
    // Read data stands for one cycle only, so it is sampled right after the taking edge
    task automatic rd_reg(input logic [7:0] a);
        @(posedge ref_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        #1;
        chk(rdata, a == 8'h9d ? 8'(mode_m) : a == 8'h9f ? 8'(mux_m) : 8'h00, "read");
    endtask
    task automatic drive_edge(input logic v);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        raw <= v;
        while (n < 8)
        begin
            @(posedge ref_clk_in);
            #1;
            if (state === v)
                break;
            n++;
        end
        if (n == 8)
        begin
            failures++;
            tally_and_finish();
        end
        else
        begin
            // Three edges from first sampling to the level change
            chk(8'(n), 8'h03, "sync delay");
            if (en && v)
                rf_m = 1;
            if (en && !v)
                ff_m = 1;
            chk({7'h00, rflag}, 8'(rf_m), "rise flag");
            chk({7'h00, fflag}, 8'(ff_m), "fall flag");
            check_outs();
            @(posedge ref_clk_in);
            #1;
            chk({7'h00, port}, {7'h00, en & v}, "port");
        end
    endtask
    task automatic clr(input logic r, input logic f);
        @(posedge ref_clk_in);
        rclr <= r;
        fclr <= f;
        @(posedge ref_clk_in);
        rclr <= 1'b0;
        fclr <= 1'b0;
        rf_m = r ? 0 : rf_m;
        ff_m = f ? 0 : ff_m;
        #1;
        chk({6'h00, rflag, fflag}, 8'({rf_m[0], ff_m[0]}), "clear");
        check_outs();
    endtask
    // ==========================================================
    // Hang guard and main sequence
    initial
    begin
        repeat (20000) @(posedge ref_clk_in);
        failures++;
        tally_and_finish();
    end
    initial
    begin
        repeat (5) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        for (i = 0; i < 2; i++)
        begin
            rd_reg(cmpmx_pkg::CMPMX_ADDR_MODE);
            rd_reg(cmpmx_pkg::CMPMX_ADDR_MUX);
            check_outs();
            chk({6'h00, rflag, fflag}, 8'h00, "reset flags");
            chk({7'h00, port}, 8'h00, "reset port");
            // Every response mode, with junk aimed at the unused bits
            for (int k = 0; k < 4; k++)
            begin
                wr_reg(cmpmx_pkg::CMPMX_ADDR_MODE, (rnd() & 8'hcc) | 8'(k));
                rd_reg(cmpmx_pkg::CMPMX_ADDR_MODE);
            end
            // Every select code on both inputs, reversed order on the plus side
            for (int k = 0; k < 8; k++)
            begin
                wr_reg(cmpmx_pkg::CMPMX_ADDR_MUX, (rnd() & 8'h88) | 8'(k << 4) | 8'(7 - k));
                rd_reg(cmpmx_pkg::CMPMX_ADDR_MUX);
            end
            // Rail sensing pairs the internal plus net with the rail pin
            wr_reg(cmpmx_pkg::CMPMX_ADDR_MUX, 8'h33);
            // Random traffic, unmapped neighbours included
            for (int k = 0; k < 16; k++)
            begin
                ra = 8'h9c + (rnd() & 8'h03);
                wr_reg(ra, rnd());
                rd_reg(ra);
            end
            @(posedge ref_clk_in);
            en <= 1'b1;
            // All enable pairs against both edge directions
            for (int k = 0; k < 4; k++)
            begin
                wr_reg(cmpmx_pkg::CMPMX_ADDR_MODE, 8'(k << 4) | 8'h01);
                drive_edge(1'b1);
                drive_edge(1'b0);
                clr(1'b1, 1'b0);
                clr(1'b0, 1'b1);
            end
            // Clear landing on the edge that sets the flag: the set must win
            @(posedge ref_clk_in);
            raw <= 1'b1;
            repeat (3) @(posedge ref_clk_in);
            rclr <= 1'b1;
            @(posedge ref_clk_in);
            rclr <= 1'b0;
            rf_m = 1;
            #1;
            chk({7'h00, rflag}, 8'(rf_m), "set beats clear");
            drive_edge(1'b0);
            clr(1'b1, 1'b1);
            // Disabled comparator: level tracks, no flags, port held low
            @(posedge ref_clk_in);
            en <= 1'b0;
            drive_edge(1'b1);
            drive_edge(1'b0);
            // Second reset in mid-run brings back the reset values
            @(posedge ref_clk_in);
            nrst_in <= 1'b0;
            repeat (2) @(posedge ref_clk_in);
            nrst_in <= 1'b1;
            mode_m = 2;
            mux_m = 0;
            rf_m = 0;
            ff_m = 0;
        end
        tally_and_finish();
    end
endmodule
